/* design/fptlv_pkg.sv */
// Purpose: constants for the file parameter proprietary object encoder
// Assumes: 8-bit register port, one byte per stream beat
// Notes: object indices fix the emission order inside the container
package fptlv_pkg;
  localparam int NOBJ = 10;
  localparam int CTRL_START_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int ENV_TEMP_RSVD_BIT = 2;
  // register map
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_PRES_A = 5'h01;
  localparam logic [4:0] REG_PRES_B = 5'h02;
  localparam logic [4:0] REG_CHAR = 5'h03;
  localparam logic [4:0] REG_PWR_CLASS = 5'h04;
  localparam logic [4:0] REG_PWR_MA = 5'h05;
  localparam logic [4:0] REG_PWR_REF = 5'h06;
  localparam logic [4:0] REG_MINF0 = 5'h07;
  localparam logic [4:0] REG_MINF1 = 5'h08;
  localparam logic [4:0] REG_AVAIL_HI = 5'h09;
  localparam logic [4:0] REG_AVAIL_LO = 5'h0A;
  localparam logic [4:0] REG_RESV_HI = 5'h0B;
  localparam logic [4:0] REG_RESV_LO = 5'h0C;
  localparam logic [4:0] REG_MAX_HI = 5'h0D;
  localparam logic [4:0] REG_MAX_LO = 5'h0E;
  localparam logic [4:0] REG_FDET = 5'h0F;
  localparam logic [4:0] REG_CMDS = 5'h10;
  localparam logic [4:0] REG_ENV = 5'h11;
  localparam logic [4:0] REG_COUNT = 5'h12;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // tags and lengths
  localparam logic [7:0] TAG_CONTAINER = 8'hA5;
  localparam logic [7:0] TAG_CHAR = 8'h80;
  localparam logic [7:0] TAG_PWR = 8'h81;
  localparam logic [7:0] TAG_MINF = 8'h82;
  localparam logic [7:0] TAG_AVAIL = 8'h83;
  localparam logic [7:0] TAG_FDET = 8'h84;
  localparam logic [7:0] TAG_RESV = 8'h85;
  localparam logic [7:0] TAG_MAX = 8'h86;
  localparam logic [7:0] TAG_CMDS = 8'h87;
  localparam logic [7:0] TAG_ENV = 8'h88;
  localparam logic [7:0] LEN_ONE = 8'h01;
  localparam logic [7:0] LEN_SIZE = 8'h02;
  localparam logic [7:0] LEN_PWR = 8'h03;
  localparam logic [7:0] LEN_HDR = 8'h02;
  // field masks and ranges
  localparam logic [7:0] CHAR_MASK = 8'h7D;
  localparam logic [7:0] PWR_MA_MASK = 8'h3F;
  localparam logic [7:0] PWR_MA_MIN = 8'h01;
  localparam logic [7:0] PWR_MA_MAX = 8'h3C;
  localparam logic [7:0] FREQ_MIN = 8'h0A;
  localparam logic [7:0] FREQ_NONE = 8'hFF;
  localparam logic [7:0] FDET_MASK = 8'h01;
  localparam logic [7:0] CMDS_MASK = 8'h01;
  localparam logic [7:0] ENV_MASK = 8'h0F;
  // object indices, in emission order
  localparam logic [3:0] OBJ_CHAR = 4'h0;
  localparam logic [3:0] OBJ_PWR = 4'h1;
  localparam logic [3:0] OBJ_MINF0 = 4'h2;
  localparam logic [3:0] OBJ_MINF1 = 4'h3;
  localparam logic [3:0] OBJ_AVAIL = 4'h4;
  localparam logic [3:0] OBJ_FDET = 4'h5;
  localparam logic [3:0] OBJ_RESV = 4'h6;
  localparam logic [3:0] OBJ_MAX = 4'h7;
  localparam logic [3:0] OBJ_CMDS = 4'h8;
  localparam logic [3:0] OBJ_ENV = 4'h9;
  localparam logic [3:0] OBJ_NONE = 4'hA;
  typedef enum logic [1:0] {ST_IDLE, ST_LEN, ST_OBJ, ST_FIN} fptlv_state_t;
endpackage

/* design/fptlv_enc.sv */
// Purpose: card-side encoder of the proprietary container and its objects
// Assumes: terminal takes bytes with TX_VALID/TX_READY on CLK
// Notes: objects leave in fixed index order, same tags adjacent
// Contract
// - characteristics object is tag 80, length 01, one value byte
// - b1 allows stop at either level; b3/b4 give preferred level
// - voltage class flags are one exactly for supported classes
// - power object is tag 81, length 03: class, current, reference frequency
// - current byte upper two bits reserved, value 01 to 3C milliamperes
// - frequency bytes in 0.1 MHz steps, FF means none given
// - current is a 1 ms average at reference, or at max clock
// - minimum frequency object tag 82 length 01, value 0A to FF
// - several minimum frequency objects keep their order
// - available memory tag 83, length two or more, MSB first
// - available memory is next creatable object size, within max file size
// - file details tag 84 length 1, b1 distinguished encoding, rest reserved
// - reserved size tag 85, MSB first, zero when nothing reserved
// - max size tag 86; absent means no limit
// - supported commands tag 87 length 1, b1 power ability query
// - environment tag 88 length 01, temp class b3..b1, humidity b4
// - environment object sent whenever card supports special conditions
// - reserved characteristics bits are sent as zero
// - all objects sit in container A5 whose length covers them
// - objects with equal tags are placed next to one another
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
module fptlv_enc
  import fptlv_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // register port
  input wire logic [4:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // byte stream to terminal
  output logic [7:0] TX_DATA,
  output logic TX_VALID,
  input wire logic TX_READY,
  output logic TX_LAST
);

  logic [7:0] cfg_reg [REG_PRES_A:REG_ENV];
  fptlv_state_t st_reg;
  logic [3:0] obj_reg;
  logic [2:0] pos_reg;
  logic [3:0] emit_obj_reg;
  logic [2:0] emit_pos_reg;
  logic [7:0] data_reg;
  logic valid_reg;
  logic last_reg;
  logic [7:0] count_reg;
  logic [7:0] rdata_reg;
  logic [9:0] pres;
  logic [15:0] avail_v;
  logic [15:0] max_v;
  logic [15:0] avail_eff;
  logic [7:0] total_len;
  logic [7:0] obj_tag;
  logic [7:0] obj_len;
  logic [7:0] v0;
  logic [7:0] v1;
  logic [7:0] v2;
  logic [7:0] cur_byte;
  logic cfg_err;
  logic start;
  logic accept;
  logic busy;
  logic obj_done;
  logic [3:0] first_obj;
  logic [3:0] after_obj;

  function automatic logic [7:0] obj_vlen(input logic [3:0] o);
    logic [7:0] r;
    r = LEN_ONE;
    if (o == OBJ_PWR) begin
      r = LEN_PWR;
    end else if (o == OBJ_AVAIL || o == OBJ_RESV || o == OBJ_MAX) begin
      r = LEN_SIZE;
    end
    return r;
  endfunction

  function automatic logic [3:0] next_obj(input logic [9:0] p, input logic [4:0] from);
    logic [3:0] r;
    r = OBJ_NONE;
    for (int i = NOBJ - 1; i >= 0; i--) begin
      if (i >= int'(from) && p[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // presence and derived sizes
  assign pres = {cfg_reg[REG_PRES_B][1:0], cfg_reg[REG_PRES_A]};
  assign avail_v = {cfg_reg[REG_AVAIL_HI], cfg_reg[REG_AVAIL_LO]};
  assign max_v = {cfg_reg[REG_MAX_HI], cfg_reg[REG_MAX_LO]};
  // capped so an object of the advertised size never breaks the max size
  assign avail_eff = (pres[OBJ_MAX] && avail_v > max_v) ? max_v : avail_v;

  always_comb begin
    total_len = '0;
    for (int i = 0; i < NOBJ; i++) begin
      if (pres[i]) begin
        total_len = total_len + obj_vlen(4'(i)) + LEN_HDR;
      end
    end
  end

  // configuration checks; a bad set blocks the start
  always_comb begin
    cfg_err = 1'b0;
    if (pres[OBJ_PWR]) begin
      if ((cfg_reg[REG_PWR_MA] & PWR_MA_MASK) < PWR_MA_MIN) begin
        cfg_err = 1'b1;
      end
      if ((cfg_reg[REG_PWR_MA] & PWR_MA_MASK) > PWR_MA_MAX) begin
        cfg_err = 1'b1;
      end
      if (cfg_reg[REG_PWR_REF] < FREQ_MIN) begin
        cfg_err = 1'b1;
      end
    end
    if (pres[OBJ_MINF0] && cfg_reg[REG_MINF0] < FREQ_MIN) begin
      cfg_err = 1'b1;
    end
    if (pres[OBJ_MINF1] && cfg_reg[REG_MINF1] < FREQ_MIN) begin
      cfg_err = 1'b1;
    end
    if (pres[OBJ_ENV] && cfg_reg[REG_ENV][ENV_TEMP_RSVD_BIT]) begin
      cfg_err = 1'b1;
    end
  end

  // byte at the next position of the current object
  always_comb begin
    obj_tag = '0;
    v0 = '0;
    v1 = '0;
    v2 = '0;
    obj_len = obj_vlen(obj_reg);
    case (obj_reg)
      OBJ_CHAR: begin
        obj_tag = TAG_CHAR;
        v0 = cfg_reg[REG_CHAR] & CHAR_MASK;
      end
      OBJ_PWR: begin
        obj_tag = TAG_PWR;
        v0 = cfg_reg[REG_PWR_CLASS];
        v1 = cfg_reg[REG_PWR_MA] & PWR_MA_MASK;
        // current is the 1 ms average at this reference, or at max clock when FF
        v2 = cfg_reg[REG_PWR_REF];
      end
      OBJ_MINF0: begin
        obj_tag = TAG_MINF;
        v0 = cfg_reg[REG_MINF0];
      end
      OBJ_MINF1: begin
        obj_tag = TAG_MINF;
        v0 = cfg_reg[REG_MINF1];
      end
      OBJ_AVAIL: begin
        obj_tag = TAG_AVAIL;
        v0 = avail_eff[15:8];
        v1 = avail_eff[7:0];
      end
      OBJ_FDET: begin
        obj_tag = TAG_FDET;
        v0 = cfg_reg[REG_FDET] & FDET_MASK;
      end
      OBJ_RESV: begin
        obj_tag = TAG_RESV;
        v0 = cfg_reg[REG_RESV_HI];
        v1 = cfg_reg[REG_RESV_LO];
      end
      OBJ_MAX: begin
        obj_tag = TAG_MAX;
        v0 = max_v[15:8];
        v1 = max_v[7:0];
      end
      OBJ_CMDS: begin
        obj_tag = TAG_CMDS;
        v0 = cfg_reg[REG_CMDS] & CMDS_MASK;
      end
      OBJ_ENV: begin
        obj_tag = TAG_ENV;
        v0 = cfg_reg[REG_ENV] & ENV_MASK;
      end
      default: begin
        obj_tag = '0;
      end
    endcase
    case (pos_reg)
      3'h0: cur_byte = obj_tag;
      3'h1: cur_byte = obj_len;
      3'h2: cur_byte = v0;
      3'h3: cur_byte = v1;
      default: cur_byte = v2;
    endcase
  end

  assign busy = (st_reg != ST_IDLE);
  assign accept = valid_reg && TX_READY;
  assign start = (st_reg == ST_IDLE) && REG_WR && (REG_ADDR == REG_CTRL)
    && REG_WDATA[CTRL_START_BIT] && !cfg_err;
  assign obj_done = (pos_reg == 3'(obj_len + 8'h01));
  assign first_obj = next_obj(pres, 5'h00);
  assign after_obj = next_obj(pres, 5'({1'b0, obj_reg} + 5'h01));

  // configuration registers, frozen while a frame is out
  always_ff @(posedge CLK) begin
    if (RST) begin
      for (int i = REG_PRES_A; i <= REG_ENV; i++) begin
        cfg_reg[i] <= CFG_RESET;
      end
    end else if (REG_WR && !busy && REG_ADDR >= REG_PRES_A && REG_ADDR <= REG_ENV) begin
      cfg_reg[REG_ADDR] <= REG_WDATA;
    end
  end

  // stream sequencer
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_reg <= ST_IDLE;
      obj_reg <= OBJ_NONE;
      pos_reg <= 3'h0;
      emit_obj_reg <= OBJ_NONE;
      emit_pos_reg <= 3'h0;
      data_reg <= 8'h00;
      valid_reg <= 1'b0;
      last_reg <= 1'b0;
      count_reg <= 8'h00;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          if (start) begin
            data_reg <= TAG_CONTAINER;
            valid_reg <= 1'b1;
            last_reg <= 1'b0;
            emit_obj_reg <= OBJ_NONE;
            emit_pos_reg <= 3'h0;
            count_reg <= 8'h00;
            st_reg <= ST_LEN;
          end
        end
        ST_LEN: begin
          if (accept) begin
            data_reg <= total_len;
            emit_pos_reg <= 3'h1;
            count_reg <= count_reg + 8'h01;
            obj_reg <= first_obj;
            pos_reg <= 3'h0;
            last_reg <= (first_obj == OBJ_NONE);
            st_reg <= (first_obj == OBJ_NONE) ? ST_FIN : ST_OBJ;
          end
        end
        ST_OBJ: begin
          if (accept) begin
            data_reg <= cur_byte;
            emit_obj_reg <= obj_reg;
            emit_pos_reg <= pos_reg;
            count_reg <= count_reg + 8'h01;
            if (obj_done) begin
              obj_reg <= after_obj;
              pos_reg <= 3'h0;
              if (after_obj == OBJ_NONE) begin
                last_reg <= 1'b1;
                st_reg <= ST_FIN;
              end
            end else begin
              pos_reg <= pos_reg + 3'h1;
            end
          end
        end
        ST_FIN: begin
          if (accept) begin
            valid_reg <= 1'b0;
            last_reg <= 1'b0;
            count_reg <= count_reg + 8'h01;
            st_reg <= ST_IDLE;
          end
        end
        default: begin
          st_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // register reads, data valid the cycle after the strobe only
  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_reg <= 8'h00;
    end else if (REG_RD) begin
      if (REG_ADDR == REG_CTRL) begin
        rdata_reg <= {6'h00, cfg_err, busy};
      end else if (REG_ADDR == REG_COUNT) begin
        rdata_reg <= count_reg;
      end else if (REG_ADDR >= REG_PRES_A && REG_ADDR <= REG_ENV) begin
        rdata_reg <= cfg_reg[REG_ADDR];
      end else begin
        rdata_reg <= 8'h00;
      end
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign REG_RDATA = rdata_reg;
  assign TX_DATA = data_reg;
  assign TX_VALID = valid_reg;
  assign TX_LAST = last_reg;

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_start;
    start;
  endsequence

  sequence s_char_tag_out;
    accept && emit_obj_reg == OBJ_CHAR && emit_pos_reg == 3'h0;
  endsequence

  sequence s_len_out;
    st_reg == ST_LEN && accept;
  endsequence

  hdr_tag_a: assert property (s_start |=> TX_VALID && TX_DATA == TAG_CONTAINER)
    else $error("container tag missing after start");

  hdr_len_a: assert property (s_len_out |=> TX_DATA == $past(total_len))
    else $error("container length wrong");

  char_len_a: assert property (s_char_tag_out |=> TX_DATA == LEN_ONE)
    else $error("characteristics length not 01");

  char_bits_a: assert property (TX_VALID && emit_obj_reg == OBJ_CHAR
    && emit_pos_reg == 3'h2 |-> TX_DATA == (cfg_reg[REG_CHAR] & CHAR_MASK))
    else $error("characteristics byte wrong or reserved bit set");

  pwr_len_a: assert property (TX_VALID && emit_obj_reg == OBJ_PWR
    && emit_pos_reg == 3'h1 |-> TX_DATA == LEN_PWR)
    else $error("power object length not 03");

  pwr_range_a: assert property (TX_VALID && emit_obj_reg == OBJ_PWR
    && emit_pos_reg == 3'h3 |-> TX_DATA >= PWR_MA_MIN && TX_DATA <= PWR_MA_MAX)
    else $error("current byte out of range");

  err_refuse_a: assert property (st_reg == ST_IDLE && REG_WR && REG_ADDR == REG_CTRL
    && REG_WDATA[CTRL_START_BIT] && cfg_err |=> !TX_VALID)
    else $error("start taken with bad configuration");

  avail_cap_a: assert property (TX_VALID && emit_obj_reg == OBJ_AVAIL
    && emit_pos_reg == 3'h2 && pres[OBJ_MAX] |-> TX_DATA <= max_v[15:8])
    else $error("available memory above max size");

  fdet_rsvd_a: assert property (TX_VALID && emit_obj_reg == OBJ_FDET
    && emit_pos_reg == 3'h2 |-> TX_DATA[7:1] == 7'h00)
    else $error("file details reserved bits set");

  env_rsvd_a: assert property (TX_VALID && emit_obj_reg == OBJ_ENV
    && emit_pos_reg == 3'h2 |-> TX_DATA[7:4] == 4'h0 && !TX_DATA[2])
    else $error("environment reserved bits set");

  stall_hold_a: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("stream byte changed under stall");

endmodule

/* test/fptlv_term.sv */
// Purpose: terminal side model taking the container byte stream
// Assumes: a byte is taken at a CLK edge with TX_VALID and TX_READY high
// Notes: slow mode stalls on a pseudo random pattern
`timescale 1ns/10ps
module fptlv_term
  import fptlv_pkg::*;
#(
  // host supply figures, values of our own choosing
  parameter logic [7:0] CLASS_NOW = 8'h10,
  parameter int LIMIT_MA = 30,
  parameter int SCALE_NUM = 3,
  parameter int SCALE_DEN = 2
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // stream from card
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  input wire logic TX_LAST,
  output logic TX_READY,
  // control and capture
  input wire logic slow,
  input wire logic supply_extra,
  output logic take,
  output logic [7:0] take_data,
  output logic take_last,
  // host decisions
  output logic stop_high,
  output logic stop_low,
  output logic app_ok
);
  logic [7:0] lfsr_reg;
  logic [1:0] ph_reg;
  logic [7:0] tag_reg;
  logic [7:0] rem_reg;
  logic [7:0] vidx_reg;
  logic [7:0] char_reg;
  logic [7:0] cls_reg;
  logic [7:0] ma_reg;
  logic [7:0] ma_use;
  int ma_scaled;
  // object walk inside the container
  always_ff @(posedge CLK) begin
    if (RST) begin
      ph_reg <= 2'h0;
      tag_reg <= 8'h00;
      rem_reg <= 8'h00;
      vidx_reg <= 8'h00;
      char_reg <= 8'h00;
      cls_reg <= 8'h00;
      ma_reg <= 8'h00;
    end else if (take) begin
      if (rem_reg != 8'h00) begin
        rem_reg <= rem_reg - 8'h01;
        vidx_reg <= vidx_reg + 8'h01;
        if (tag_reg == TAG_CHAR) char_reg <= TX_DATA;
        if (tag_reg == TAG_PWR && vidx_reg == 8'h00) cls_reg <= TX_DATA;
        if (tag_reg == TAG_PWR && vidx_reg == 8'h01) ma_reg <= TX_DATA;
      end else begin
        case (ph_reg)
          2'h0: begin
            char_reg <= 8'h00;
            ma_reg <= 8'h00;
            ph_reg <= 2'h1;
          end
          2'h1: begin
            ph_reg <= 2'h2;
          end
          2'h2: begin
            tag_reg <= TX_DATA;
            ph_reg <= 2'h3;
          end
          default: begin
            // every object, known or not, is stepped over by its length byte
            rem_reg <= TX_DATA;
            vidx_reg <= 8'h00;
            ph_reg <= 2'h2;
          end
        endcase
      end
      if (TX_LAST) begin
        ph_reg <= 2'h0;
        rem_reg <= 8'h00;
      end
    end
  end
  // clock stop levels the host may use
  assign stop_high = char_reg[0] | char_reg[2];
  assign stop_low = char_reg[0] | char_reg[3];
  // reserved codes and values above range carry no current
  assign ma_use = (ma_reg == 8'h00 || ma_reg == 8'hFF || ma_reg > PWR_MA_MAX)
    ? 8'h00 : ma_reg;
  assign ma_scaled = (cls_reg == CLASS_NOW) ? int'(ma_use)
    : int'(ma_use) * SCALE_NUM / SCALE_DEN;
  assign app_ok = (ma_use == 8'h00) || (ma_scaled <= LIMIT_MA) || supply_extra;
  // bytes are handed on in arrival order, never merged or reordered
  assign take = TX_VALID & TX_READY;
  assign take_data = TX_DATA;
  assign take_last = TX_LAST;
  always_ff @(posedge CLK) begin
    if (RST) begin
      lfsr_reg <= 8'h5A;
      TX_READY <= 1'b0;
    end else begin
      lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
      TX_READY <= slow ? lfsr_reg[0] : 1'b1;
    end
  end
endmodule

/* test/tb.sv */
// Purpose: self-checking bench of the container encoder
// Assumes: terminal model takes the stream, register port driven here
// Notes: expected streams are rebuilt from the written configuration
`timescale 1ns/10ps
module tb;
  import fptlv_pkg::*;
  localparam logic [7:0] CLASS_NOW = 8'h10;
  localparam int LIMIT_MA = 30;
  localparam int SCALE_NUM = 3;
  localparam int SCALE_DEN = 2;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [4:0] REG_ADDR = 5'h00;
  logic [7:0] REG_WDATA = 8'h00;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [7:0] REG_RDATA;
  logic [7:0] TX_DATA;
  logic TX_VALID;
  logic TX_READY;
  logic TX_LAST;
  logic slow = 1'b0;
  logic supply_extra = 1'b0;
  logic stop_high;
  logic stop_low;
  logic app_ok;
  logic take;
  logic take_last;
  logic [7:0] take_data;
  logic hold = 1'b0;
  logic [7:0] hold_data = 8'h00;
  integer seed = 85231;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] cfg [0:17];
  logic [7:0] exp_q [$];
  logic [8:0] got_q [$];
  logic [7:0] rv;
  // corner table: {error expected, address, value}
  logic [13:0] corner [0:13] = '{{1'b1, REG_PWR_MA, 8'h00}, {1'b1, REG_PWR_MA, 8'h3D},
    {1'b1, REG_PWR_MA, 8'hC0}, {1'b1, REG_PWR_REF, 8'h09}, {1'b1, REG_MINF0, 8'h09},
    {1'b1, REG_ENV, 8'h04}, {1'b0, REG_PWR_MA, 8'h01}, {1'b0, REG_PWR_MA, 8'h3C},
    {1'b0, REG_PWR_MA, 8'hFC}, {1'b0, REG_PWR_REF, 8'h0A}, {1'b0, REG_PWR_REF, 8'hFF},
    {1'b0, REG_MINF0, 8'hFF}, {1'b0, REG_ENV, 8'h0B}, {1'b0, REG_ENV, 8'hF3}};

  fptlv_enc fptlv_enc_inst (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .TX_DATA(TX_DATA),
    .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_LAST(TX_LAST));
  fptlv_term #(.CLASS_NOW(CLASS_NOW), .LIMIT_MA(LIMIT_MA), .SCALE_NUM(SCALE_NUM),
    .SCALE_DEN(SCALE_DEN)) fptlv_term_inst (.CLK(CLK), .RST(RST), .TX_DATA(TX_DATA),
    .TX_VALID(TX_VALID), .TX_LAST(TX_LAST), .TX_READY(TX_READY), .slow(slow),
    .supply_extra(supply_extra), .take(take), .take_data(take_data), .take_last(take_last),
    .stop_high(stop_high), .stop_low(stop_low), .app_ok(app_ok));

  always #10 CLK = ~CLK;

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("unexpected timeout: expected end seen hang");
      stop_test();
    end
    if (take === 1'b1) got_q.push_back({take_last, take_data});
    if (hold === 1'b1) chk("stalled byte", hold_data, TX_DATA);
    hold <= TX_VALID & ~TX_READY;
    hold_data <= TX_DATA;
  end

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask

  // expected container: objects in index order, equal tags adjacent
  function automatic void build();
    logic [7:0] b [$];
    logic [15:0] av;
    logic [15:0] mx;
    b = {};
    av = {cfg[REG_AVAIL_HI], cfg[REG_AVAIL_LO]};
    mx = {cfg[REG_MAX_HI], cfg[REG_MAX_LO]};
    if (cfg[REG_PRES_A][7] && mx < av) av = mx;
    if (cfg[REG_PRES_A][0]) b = {b, TAG_CHAR, LEN_ONE, cfg[REG_CHAR] & CHAR_MASK};
    if (cfg[REG_PRES_A][1]) b = {b, TAG_PWR, LEN_PWR, cfg[REG_PWR_CLASS],
      cfg[REG_PWR_MA] & PWR_MA_MASK, cfg[REG_PWR_REF]};
    if (cfg[REG_PRES_A][2]) b = {b, TAG_MINF, LEN_ONE, cfg[REG_MINF0]};
    if (cfg[REG_PRES_A][3]) b = {b, TAG_MINF, LEN_ONE, cfg[REG_MINF1]};
    if (cfg[REG_PRES_A][4]) b = {b, TAG_AVAIL, LEN_SIZE, av[15:8], av[7:0]};
    if (cfg[REG_PRES_A][5]) b = {b, TAG_FDET, LEN_ONE, cfg[REG_FDET] & FDET_MASK};
    if (cfg[REG_PRES_A][6]) b = {b, TAG_RESV, LEN_SIZE, cfg[REG_RESV_HI], cfg[REG_RESV_LO]};
    if (cfg[REG_PRES_A][7]) b = {b, TAG_MAX, LEN_SIZE, mx[15:8], mx[7:0]};
    if (cfg[REG_PRES_B][0]) b = {b, TAG_CMDS, LEN_ONE, cfg[REG_CMDS] & CMDS_MASK};
    if (cfg[REG_PRES_B][1]) b = {b, TAG_ENV, LEN_ONE, cfg[REG_ENV] & ENV_MASK};
    exp_q = {TAG_CONTAINER, 8'(b.size()), b};
  endfunction

  task automatic base();
    foreach (cfg[i]) cfg[i] = 8'h00;
    cfg[REG_PRES_A] = 8'h06;
    cfg[REG_PRES_B] = 8'h02;
    cfg[REG_PWR_CLASS] = 8'($random(seed));
    cfg[REG_PWR_MA] = 8'h10;
    cfg[REG_PWR_REF] = 8'h0A;
    cfg[REG_MINF0] = 8'h0A;
  endtask

  task automatic rnd_cfg();
    foreach (cfg[i]) cfg[i] = 8'($random(seed));
    cfg[REG_PWR_MA] = 8'(1 + {$random(seed)} % 60);
    cfg[REG_PWR_REF] = 8'(8'h0A + {$random(seed)} % 246);
    cfg[REG_MINF0] = 8'(8'h0A + {$random(seed)} % 246);
    cfg[REG_MINF1] = 8'(8'h0A + {$random(seed)} % 246);
    cfg[REG_ENV] = cfg[REG_ENV] & 8'hFB;
  endtask

  task automatic run_frame(input logic bad, input logic poke);
    int n;
    logic [7:0] c;
    int s;
    for (int i = 1; i < 18; i++) wr(5'(i), cfg[i]);
    build();
    got_q = {};
    wr(REG_CTRL, 8'h01);
    if (poke) begin
      wr(REG_CHAR, ~cfg[REG_CHAR]);
      wr(REG_CTRL, 8'h01);
    end
    n = 0;
    if (bad) repeat (40) @(posedge CLK);
    else while (n < 600 && !(got_q.size() > 0 && got_q[$][8] === 1'b1)) begin
      @(posedge CLK);
      n++;
    end
    chk("frame size", 8'(bad ? 0 : exp_q.size()), 8'(got_q.size()));
    if (!bad && got_q.size() == exp_q.size()) foreach (exp_q[i]) begin
      chk("stream byte", exp_q[i], got_q[i][7:0]);
      chk("last flag", 8'(i == exp_q.size() - 1), 8'(got_q[i][8]));
    end
    rd(REG_CTRL, rv);
    chk("status", {6'h00, bad, 1'b0}, rv);
    if (!bad) begin
      rd(REG_COUNT, rv);
      chk("byte count", 8'(exp_q.size()), rv);
      c = cfg[REG_PRES_A][0] ? cfg[REG_CHAR] & CHAR_MASK : 8'h00;
      chk("stop levels", {6'h00, c[0] | c[3], c[0] | c[2]}, {6'h00, stop_low, stop_high});
      s = cfg[REG_PRES_A][1] ? int'(cfg[REG_PWR_MA] & PWR_MA_MASK) : 0;
      if (cfg[REG_PWR_CLASS] != CLASS_NOW) s = s * SCALE_NUM / SCALE_DEN;
      chk("host accept", 8'(s <= LIMIT_MA || supply_extra), 8'(app_ok));
    end
  endtask

  initial begin
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    rd(REG_CTRL, rv);
    chk("status after reset", 8'h00, rv);
    rd(REG_CHAR, rv);
    chk("char after reset", CFG_RESET, rv);
    rd(5'h1F, rv);
    chk("unmapped read", 8'h00, rv);
    // empty container, the length byte alone carries the last flag
    foreach (cfg[i]) cfg[i] = 8'h00;
    run_frame(1'b0, 1'b0);
    // lone characteristics objects, reserved bits set on purpose in all but the first
    for (int k = 0; k < 4; k++) begin
      foreach (cfg[i]) cfg[i] = 8'h00;
      cfg[REG_PRES_A] = 8'h01;
      cfg[REG_CHAR] = k == 0 ? 8'h01 : 8'($random(seed)) | 8'h82;
      run_frame(1'b0, 1'b0);
    end
    // every object, memory above the size limit, stalls and writes while busy
    rnd_cfg();
    cfg[REG_PRES_A] = 8'hFF;
    cfg[REG_PRES_B] = 8'h03;
    {cfg[REG_AVAIL_HI], cfg[REG_AVAIL_LO]} = 16'h1234;
    {cfg[REG_MAX_HI], cfg[REG_MAX_LO]} = 16'h0123;
    slow <= 1'b1;
    run_frame(1'b0, 1'b1);
    slow <= 1'b0;
    foreach (corner[k]) begin
      base();
      cfg[corner[k][12:8]] = corner[k][7:0];
      run_frame(corner[k][13], 1'b0);
    end
    for (int k = 0; k < 20; k++) begin
      rnd_cfg();
      slow <= k[0];
      supply_extra <= k[1];
      if (k[2]) cfg[REG_PWR_CLASS] = CLASS_NOW;
      run_frame(1'b0, 1'b0);
    end
    stop_test();
  end
endmodule
